// ==== verilog/crf_flow.v ====
`timescale 1ns/1ns
// Contract
// - Relative call decoded by top five bits; low eleven bits are offset
// - Call offset is two's complement, -1024 to +1023 words
// - Relative call pushes counter plus two onto return stack first
// - Relative call loads counter plus two plus twice the offset
// - Relative call takes two cycles, the second idle
// - Software reset instruction causes the master clear reset
// - After software reset every register and flag holds reset value
// - Interrupt return pops stack into counter; low opcode bit selects
// - Interrupt return sets high or low priority global enable
// - Select bit one restores working, status, bank from shadows
// - Returns leave upper and high counter latches untouched
// - Literal return writes its eight bit literal to working register
// - Literal return pops stack into counter in same final phase
// - Plain return pops to counter and optionally restores shadows
`include "crf_regs.vh"
module crf_flow (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // Core status
    output reg exec_busy_q,
    output reg master_clear_req_q
);

    // Reset release
    reg [1:0] rs_q;
    wire rst_i_n;

    // Bus pipeline
    reg ap_valid_q;
    reg ap_write_q;
    reg [7:0] ap_addr_q;
    reg rd_pend_q;
    wire acc;
    wire wr_go;
    reg [31:0] rd_d;

    // Core state
    reg [15:0] ir_q;
    reg [20:0] pc_q;
    reg [7:0] w_q;
    reg [4:0] stat_q;
    reg [3:0] bsr_q;
    reg [7:0] ws_q;
    reg [4:0] shadow_status_reg_q;
    reg [3:0] shadow_bank_select_reg_q;
    reg high_prio_global_int_enable_q;
    reg low_prio_global_int_enable_q;
    reg lowisr_q;
    reg [7:0] pc_high_latch_q;
    reg [4:0] pc_upper_latch_q;
    reg [4:0] sp_q;
    reg ovf_q;
    reg unf_q;
    reg [1:0] q_q;
    reg cyc_q;
    reg ncyc_q;
    reg clr_q;

    // Return stack
    reg [20:0] stk [0:30];
    wire [20:0] stack_top_entry;
    wire stk_full;
    wire stk_empty;
    wire push_en;
    wire tos_wr;

    // Decoder outputs
    wire d_relative_call;
    wire d_reset;
    wire d_return_from_interrupt;
    wire d_return;
    wire d_return_with_literal;
    wire d_s;
    wire d_two;
    wire [7:0] d_lit;
    wire [20:0] d_next;
    wire [20:0] d_target;

    // Phase strobes of the running instruction
    wire ph_q1;
    wire ph_q2;
    wire ph_q4;
    wire any_ret;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rs_q <= 2'b00;
        else
            rs_q <= {rs_q[0], 1'b1};
    end

    assign rst_i_n = rs_q[1];

    crf_decode u_dec (
        .instr(ir_q),
        .pc(pc_q),
        .is_relative_call(d_relative_call),
        .is_reset(d_reset),
        .is_return_from_interrupt(d_return_from_interrupt),
        .is_return(d_return),
        .is_return_with_literal(d_return_with_literal),
        .restore_sel(d_s),
        .two_cycle(d_two),
        .literal(d_lit),
        .next_pc(d_next),
        .call_target(d_target)
    );

    assign acc = hsel & hready & htrans[1];
    assign wr_go = ap_valid_q & ap_write_q;

    assign stk_empty = sp_q == 5'h00;
    assign stk_full = sp_q == `CRF_STK_DEPTH;
    assign stack_top_entry = stk_empty ? 21'h000000 : stk[sp_q - 5'h01];

    assign ph_q1 = exec_busy_q & ~cyc_q & (q_q == 2'h0);
    assign ph_q2 = exec_busy_q & ~cyc_q & (q_q == `CRF_Q_PUSH);
    assign ph_q4 = exec_busy_q & ~cyc_q & (q_q == `CRF_Q_LAST);
    assign any_ret = d_return_from_interrupt | d_return | d_return_with_literal;

    // Push happens in Q2, ahead of the counter write in Q4
    assign push_en = ph_q2 & d_relative_call & ~stk_full & ~clr_q;
    assign tos_wr = wr_go & (ap_addr_q == `CRF_OFS_TOS) & ~stk_empty;

    // Stack words carry no reset; the pointer says what is valid
    always @(posedge mclk)
    begin
        if (push_en)
            stk[sp_q] <= d_next;
        else if (tos_wr)
            stk[sp_q - 5'h01] <= hwdata[20:0];
    end

    // Read mux, addressed from the captured address phase
    always @*
    begin
        rd_d = 32'h00000000;
        if (ap_addr_q == `CRF_OFS_INSTR)
            rd_d[15:0] = ir_q;
        else if (ap_addr_q == `CRF_OFS_PC)
            rd_d[20:0] = pc_q;
        else if (ap_addr_q == `CRF_OFS_WREG)
            rd_d[7:0] = w_q;
        else if (ap_addr_q == `CRF_OFS_STATUS)
            rd_d[4:0] = stat_q;
        else if (ap_addr_q == `CRF_OFS_BSR)
            rd_d[3:0] = bsr_q;
        else if (ap_addr_q == `CRF_OFS_SHADOW)
        begin
            rd_d[`CRF_SHD_WS_LSB+7:`CRF_SHD_WS_LSB] = ws_q;
            rd_d[`CRF_SHD_SHADOW_STATUS_REG_LSB+4:`CRF_SHD_SHADOW_STATUS_REG_LSB] = shadow_status_reg_q;
            rd_d[`CRF_SHD_SHADOW_BANK_SELECT_REG_LSB+3:`CRF_SHD_SHADOW_BANK_SELECT_REG_LSB] = shadow_bank_select_reg_q;
        end
        else if (ap_addr_q == `CRF_OFS_INTCTL)
        begin
            rd_d[`CRF_INT_HIGH_PRIO_GLOBAL_INT_ENABLE_BIT] = high_prio_global_int_enable_q;
            rd_d[`CRF_INT_LOW_PRIO_GLOBAL_INT_ENABLE_BIT] = low_prio_global_int_enable_q;
            rd_d[`CRF_INT_LOWISR_BIT] = lowisr_q;
        end
        else if (ap_addr_q == `CRF_OFS_PCLAT)
        begin
            rd_d[`CRF_PCLAT_HIGH_LSB+7:`CRF_PCLAT_HIGH_LSB] = pc_high_latch_q;
            rd_d[`CRF_PCLAT_UPPER_LSB+4:`CRF_PCLAT_UPPER_LSB] = pc_upper_latch_q;
        end
        else if (ap_addr_q == `CRF_OFS_TOS)
            rd_d[20:0] = stack_top_entry;
        else if (ap_addr_q == `CRF_OFS_CORESTAT)
        begin
            rd_d[`CRF_CST_BUSY_BIT] = exec_busy_q;
            rd_d[`CRF_CST_CYC_BIT] = cyc_q;
            rd_d[`CRF_CST_SP_LSB+4:`CRF_CST_SP_LSB] = sp_q;
            rd_d[`CRF_CST_OVF_BIT] = ovf_q;
            rd_d[`CRF_CST_UNF_BIT] = unf_q;
        end
    end

    // Bus slave: writes zero wait, reads one wait state
    always @(posedge mclk or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 8'h00;
            rd_pend_q <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end
        else
        begin
            hresp <= 1'b0;
            if (rd_pend_q)
            begin
                hrdata <= rd_d;
                hreadyout <= 1'b1;
                rd_pend_q <= 1'b0;
                ap_valid_q <= 1'b0;
            end
            else if (acc)
            begin
                ap_valid_q <= 1'b1;
                ap_write_q <= hwrite;
                ap_addr_q <= haddr[7:0];
                rd_pend_q <= ~hwrite;
                hreadyout <= hwrite;
            end
            else
                ap_valid_q <= 1'b0;
        end
    end

    // Core state; execution assignments follow bus writes so they win
    always @(posedge mclk or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            ir_q <= `CRF_RST_INSTR;
            pc_q <= `CRF_RST_PC;
            w_q <= `CRF_RST_W;
            stat_q <= `CRF_RST_STATUS;
            bsr_q <= `CRF_RST_BSR;
            ws_q <= `CRF_RST_W;
            shadow_status_reg_q <= `CRF_RST_STATUS;
            shadow_bank_select_reg_q <= `CRF_RST_BSR;
            high_prio_global_int_enable_q <= 1'b0;
            low_prio_global_int_enable_q <= 1'b0;
            lowisr_q <= 1'b0;
            pc_high_latch_q <= `CRF_RST_PC_HIGH_LATCH;
            pc_upper_latch_q <= `CRF_RST_PC_UPPER_LATCH;
            sp_q <= 5'h00;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            q_q <= 2'h0;
            cyc_q <= 1'b0;
            ncyc_q <= 1'b0;
            clr_q <= 1'b0;
            exec_busy_q <= 1'b0;
            master_clear_req_q <= 1'b0;
        end
        else if (clr_q)
        begin
            ir_q <= `CRF_RST_INSTR;
            pc_q <= `CRF_RST_PC;
            w_q <= `CRF_RST_W;
            stat_q <= `CRF_RST_STATUS;
            bsr_q <= `CRF_RST_BSR;
            ws_q <= `CRF_RST_W;
            shadow_status_reg_q <= `CRF_RST_STATUS;
            shadow_bank_select_reg_q <= `CRF_RST_BSR;
            high_prio_global_int_enable_q <= 1'b0;
            low_prio_global_int_enable_q <= 1'b0;
            lowisr_q <= 1'b0;
            pc_high_latch_q <= `CRF_RST_PC_HIGH_LATCH;
            pc_upper_latch_q <= `CRF_RST_PC_UPPER_LATCH;
            sp_q <= 5'h00;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            q_q <= 2'h0;
            cyc_q <= 1'b0;
            ncyc_q <= 1'b0;
            clr_q <= 1'b0;
            exec_busy_q <= 1'b0;
            master_clear_req_q <= 1'b0;
        end
        else
        begin
            if (wr_go)
            begin
                if (ap_addr_q == `CRF_OFS_INSTR)
                begin
                    if (!exec_busy_q)
                    begin
                        ir_q <= hwdata[15:0];
                        exec_busy_q <= 1'b1;
                        q_q <= 2'h0;
                        cyc_q <= 1'b0;
                    end
                end
                else if (ap_addr_q == `CRF_OFS_PC)
                begin
                    if (!exec_busy_q)
                        pc_q <= hwdata[20:0];
                end
                else if (ap_addr_q == `CRF_OFS_WREG)
                    w_q <= hwdata[7:0];
                else if (ap_addr_q == `CRF_OFS_STATUS)
                    stat_q <= hwdata[4:0];
                else if (ap_addr_q == `CRF_OFS_BSR)
                    bsr_q <= hwdata[3:0];
                else if (ap_addr_q == `CRF_OFS_SHADOW)
                begin
                    ws_q <= hwdata[`CRF_SHD_WS_LSB+7:`CRF_SHD_WS_LSB];
                    shadow_status_reg_q <=
                        hwdata[`CRF_SHD_SHADOW_STATUS_REG_LSB+4:`CRF_SHD_SHADOW_STATUS_REG_LSB];
                    shadow_bank_select_reg_q <= hwdata[`CRF_SHD_SHADOW_BANK_SELECT_REG_LSB+3:`CRF_SHD_SHADOW_BANK_SELECT_REG_LSB];
                end
                else if (ap_addr_q == `CRF_OFS_INTCTL)
                begin
                    high_prio_global_int_enable_q <= hwdata[`CRF_INT_HIGH_PRIO_GLOBAL_INT_ENABLE_BIT];
                    low_prio_global_int_enable_q <= hwdata[`CRF_INT_LOW_PRIO_GLOBAL_INT_ENABLE_BIT];
                    lowisr_q <= hwdata[`CRF_INT_LOWISR_BIT];
                end
                else if (ap_addr_q == `CRF_OFS_PCLAT)
                begin
                    pc_high_latch_q <=
                        hwdata[`CRF_PCLAT_HIGH_LSB+7:`CRF_PCLAT_HIGH_LSB];
                    pc_upper_latch_q <=
                        hwdata[`CRF_PCLAT_UPPER_LSB+4:`CRF_PCLAT_UPPER_LSB];
                end
                else if (ap_addr_q == `CRF_OFS_CORESTAT)
                begin
                    if (hwdata[`CRF_CST_OVF_BIT])
                        ovf_q <= 1'b0;
                    if (hwdata[`CRF_CST_UNF_BIT])
                        unf_q <= 1'b0;
                end
            end

            // Four Q phases per instruction cycle
            if (exec_busy_q)
            begin
                q_q <= q_q + 2'h1;
                if (q_q == `CRF_Q_LAST)
                begin
                    if (cyc_q == ncyc_q)
                        exec_busy_q <= 1'b0;
                    else
                        cyc_q <= 1'b1;
                end
            end

            if (ph_q1)
                ncyc_q <= d_two;

            if (ph_q2 & d_relative_call)
            begin
                if (stk_full)
                    ovf_q <= 1'b1;
                else
                    sp_q <= sp_q + 5'h01;
            end

            // Software reset starts in Q2 of its only cycle
            if (ph_q2 & d_reset)
            begin
                clr_q <= 1'b1;
                master_clear_req_q <= 1'b1;
            end

            if (ph_q4)
            begin
                if (d_relative_call)
                    pc_q <= d_target;
                else if (any_ret)
                begin
                    // Counter latches are not touched here
                    pc_q <= stack_top_entry;
                    if (stk_empty)
                        unf_q <= 1'b1;
                    else
                        sp_q <= sp_q - 5'h01;
                end
                else if (!d_reset)
                    pc_q <= d_next;

                if (d_return_from_interrupt)
                begin
                    if (lowisr_q)
                        low_prio_global_int_enable_q <= 1'b1;
                    else
                        high_prio_global_int_enable_q <= 1'b1;
                end

                if ((d_return_from_interrupt | d_return) & d_s)
                begin
                    w_q <= ws_q;
                    stat_q <= shadow_status_reg_q;
                    bsr_q <= shadow_bank_select_reg_q;
                end

                if (d_return_with_literal)
                    w_q <= d_lit;
            end
        end
    end

endmodule

// ==== verilog/crf_regs.vh ====
`ifndef CRF_REGS_VH
`define CRF_REGS_VH

// Register byte offsets
`define CRF_OFS_INSTR 8'h00
`define CRF_OFS_PC 8'h04
`define CRF_OFS_WREG 8'h08
`define CRF_OFS_STATUS 8'h0c
`define CRF_OFS_BSR 8'h10
`define CRF_OFS_SHADOW 8'h14
`define CRF_OFS_INTCTL 8'h18
`define CRF_OFS_PCLAT 8'h1c
`define CRF_OFS_TOS 8'h20
`define CRF_OFS_CORESTAT 8'h24

// Field positions
`define CRF_SHD_WS_LSB 0
`define CRF_SHD_SHADOW_STATUS_REG_LSB 8
`define CRF_SHD_SHADOW_BANK_SELECT_REG_LSB 16
`define CRF_INT_HIGH_PRIO_GLOBAL_INT_ENABLE_BIT 0
`define CRF_INT_LOW_PRIO_GLOBAL_INT_ENABLE_BIT 1
`define CRF_INT_LOWISR_BIT 2
`define CRF_PCLAT_HIGH_LSB 0
`define CRF_PCLAT_UPPER_LSB 8
`define CRF_CST_BUSY_BIT 0
`define CRF_CST_CYC_BIT 1
`define CRF_CST_SP_LSB 2
`define CRF_CST_OVF_BIT 7
`define CRF_CST_UNF_BIT 8

// Reset values
`define CRF_RST_PC 21'h000000
`define CRF_RST_W 8'h00
`define CRF_RST_STATUS 5'h00
`define CRF_RST_BSR 4'h0
`define CRF_RST_PC_HIGH_LATCH 8'h00
`define CRF_RST_PC_UPPER_LATCH 5'h00
`define CRF_RST_INSTR 16'h0000

// Opcode patterns
`define CRF_OP_RELATIVE_CALL 5'h1b
`define CRF_OP_RESET 16'h00ff
`define CRF_OP_RETURN_FROM_INTERRUPT 15'h0008
`define CRF_OP_RETURN 15'h0009
`define CRF_OP_RETURN_WITH_LITERAL 8'h0c

// Timing and sizes
`define CRF_Q_LAST 2'h3
`define CRF_Q_PUSH 2'h1
`define CRF_STK_DEPTH 5'h1f
`define CRF_PC_STEP 21'h000002

`endif

// ==== verilog/crf_decode.v ====
`timescale 1ns/1ns
`include "crf_regs.vh"
module crf_decode (
    // Instruction and counter
    input wire [15:0] instr,
    input wire [20:0] pc,
    // Decoded instruction class
    output wire is_relative_call,
    output wire is_reset,
    output wire is_return_from_interrupt,
    output wire is_return,
    output wire is_return_with_literal,
    output wire restore_sel,
    output wire two_cycle,
    // Operands
    output wire [7:0] literal,
    output wire [20:0] next_pc,
    output wire [20:0] call_target
);

    // Eleven bit signed word offset, -1024..1023
    wire [20:0] offset;

    assign is_relative_call = instr[15:11] == `CRF_OP_RELATIVE_CALL;
    assign is_reset = instr == `CRF_OP_RESET;
    assign is_return_from_interrupt = instr[15:1] == `CRF_OP_RETURN_FROM_INTERRUPT;
    assign is_return = instr[15:1] == `CRF_OP_RETURN;
    assign is_return_with_literal = instr[15:8] == `CRF_OP_RETURN_WITH_LITERAL;
    assign restore_sel = instr[0];
    assign literal = instr[7:0];
    assign two_cycle = is_relative_call | is_return_from_interrupt | is_return | is_return_with_literal;
    assign offset = {{10{instr[10]}}, instr[10:0]};
    assign next_pc = pc + `CRF_PC_STEP;
    // Byte address: word offset doubled
    assign call_target = next_pc + {offset[19:0], 1'b0};

endmodule

// ==== bench/crf_flow_assertions.sv ====
`timescale 1ns/1ns
module crf_flow_chk (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Status
    input wire exec_busy_q,
    input wire master_clear_req_q
);
    reg wr_pend_q;
    wire take = hsel & hready & htrans[1];
    wire iss = wr_pend_q & ~exec_busy_q;
    wire [15:0] op = hwdata[15:0];
    wire is_call = iss & (op[15:11] == 5'h1b);
    wire is_one = iss & (op[15:11] == 5'h1a);
    wire is_ret = iss & (op[15:2] == 14'h0004 || op[15:8] == 8'h0c);
    wire is_rst = iss & (op == 16'h00ff);

    // Instruction register write in its data phase
    always @(posedge mclk or negedge rst_n)
        if (!rst_n)
            wr_pend_q <= 1'b0;
        else if (hready)
            wr_pend_q <= take & hwrite & (haddr[7:0] == 8'h00);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence busy8;
        exec_busy_q[*8] ##1 !exec_busy_q;
    endsequence
    sequence clr_pulse;
        !master_clear_req_q[*2] ##1 master_clear_req_q ##1 !master_clear_req_q;
    endsequence

    call_cycles_a: assert property (is_call |=> busy8)
        else $error("call busy length wrong");
    ret_cycles_a: assert property (is_ret |=> busy8)
        else $error("return busy length wrong");
    noncall_short_a: assert property (
        is_one |=> exec_busy_q[*4] ##1 !exec_busy_q)
        else $error("non call opcode not one cycle");
    clear_pulse_a: assert property (is_rst |=> clr_pulse)
        else $error("software clear pulse wrong");
    reset_busy_a: assert property (
        is_rst |=> exec_busy_q[*3] ##1 !exec_busy_q)
        else $error("software clear busy length wrong");
    clear_cause_a: assert property (
        master_clear_req_q |-> $past(is_rst, 3))
        else $error("clear pulse without opcode");
    busy_cause_a: assert property ($rose(exec_busy_q) |-> $past(iss))
        else $error("busy without issue");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    okay_resp_a: assert property (!hresp)
        else $error("response not okay");
endmodule

bind crf_flow crf_flow_chk u_chk (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .exec_busy_q(exec_busy_q),
    .master_clear_req_q(master_clear_req_q));

// ==== bench/crf_flow_tb.sv ====
`timescale 1ns/1ns
module crf_flow_tb;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0;
    wire hready;
    wire hresp;
    wire [31:0] hrdata;
    wire exec_busy_q;
    wire master_clear_req_q;
    integer mismatches = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer i;
    reg rd_pend = 1'b0;
    reg [31:0] qe[$];
    reg [7:0] qa[$];
    reg [20:0] pc;
    reg [20:0] tgt[0:3];
    reg [10:0] n;
    reg [31:0] sh, lat, ctl, w;
    reg [15:0] op;
    reg s;

    always #25 mclk = ~mclk;

    crf_flow dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .exec_busy_q(exec_busy_q),
        .master_clear_req_q(master_clear_req_q));

    task check(input [7:0] a, input [31:0] seen, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("Error hrdata at %h expected %h seen %h", a, exp, seen);
        end
    end
    endtask

    task results;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // Read data monitor
    always @(posedge mclk)
    begin
        if (rd_pend && hready)
        begin
            rd_pend = 1'b0;
            check(qa.pop_front(), hrdata, qe.pop_front());
        end
        if (hsel && hready && htrans[1] && !hwrite)
            rd_pend = 1'b1;
    end

    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            results;
        end
    end

    task xfer(input wr, input [7:0] a, input [31:0] d);
    begin
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
    end
    endtask

    task rd(input [7:0] a, input [31:0] e);
    begin
        qa.push_back(a);
        qe.push_back(e);
        xfer(1'b0, a, 32'h0);
    end
    endtask

    task run(input [15:0] o);
    begin
        xfer(1'b1, 8'h00, {16'h0, o});
        @(posedge mclk);
        while (exec_busy_q !== 1'b0) @(posedge mclk);
    end
    endtask

    initial
    begin
        i = $urandom(27);
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        // Calls at both offset limits and two random
        w = $urandom;
        lat = w & 32'h1fff;
        xfer(1'b1, 8'h1c, lat);
        for (i = 0; i < 4; i = i + 1)
        begin
            w = $urandom;
            pc = {w[20:1], 1'b0};
            n = (i == 0) ? 11'h400 : (i == 1) ? 11'h3ff : w[31:21];
            xfer(1'b1, 8'h04, {11'h0, pc});
            run({5'h1b, n});
            tgt[i] = pc + 21'h2;
            rd(8'h20, {11'h0, tgt[i]});
            pc = pc + 21'h2 + {{9{n[10]}}, n, 1'b0};
            rd(8'h04, {11'h0, pc});
            rd(8'h24, ((i + 1) << 2) | 32'h2);
        end
        run(16'hd000);
        rd(8'h04, {11'h0, pc + 21'h2});
        $display("test calls done");
        // Each return kind; interrupt return with and without restore, plain return with restore only
        xfer(1'b1, 8'h18, 32'h0);
        for (i = 3; i >= 0; i = i - 1)
        begin
            w = $urandom;
            sh = w & 32'hf1fff;
            xfer(1'b1, 8'h14, sh);
            xfer(1'b1, 8'h08, 32'h5a);
            xfer(1'b1, 8'h0c, 32'h15);
            xfer(1'b1, 8'h10, 32'h9);
            if (i == 0)
                xfer(1'b1, 8'h18, 32'h4);
            op = (i == 3) ? {8'h0c, w[31:24]} : (i == 2) ? 16'h0013 :
                (i == 1) ? 16'h0010 : 16'h0011;
            s = (i != 3) && op[0];
            ctl = (i == 1) ? 32'h1 : (i == 0) ? 32'h6 : 32'h0;
            run(op);
            rd(8'h04, {11'h0, tgt[i]});
            rd(8'h08, s ? sh[7:0] : (i == 3) ? w[31:24] : 8'h5a);
            rd(8'h0c, s ? sh[12:8] : 5'h15);
            rd(8'h10, s ? sh[19:16] : 4'h9);
            rd(8'h18, ctl);
            rd(8'h1c, lat);
        end
        $display("test returns done");
        // Second issue while busy is dropped
        xfer(1'b1, 8'h00, 32'h0c33);
        xfer(1'b1, 8'h00, 32'h0c77);
        @(posedge mclk);
        while (exec_busy_q !== 1'b0) @(posedge mclk);
        rd(8'h08, 32'h33);
        $display("test busy issue done");
        // Software clear with stack, latches and flags set
        run({5'h1b, 11'h005});
        run(16'h00ff);
        for (i = 4; i <= 60; i = i + 4)
            rd(i[7:0], 32'h0);
        $display("test software clear done");
        @(posedge mclk);
        results;
    end
endmodule
